// ### rtl/gpc_cfg.svh
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH

// Register indices; byte address is four times the index
`define GPC_IDX_PA_PINS 8'h05
`define GPC_IDX_PB_PINS 8'h06
`define GPC_IDX_PC_PINS 8'h07
`define GPC_IDX_INT_CTRL 8'h0b
`define GPC_IDX_OPTION 8'h81
`define GPC_IDX_PA_DIR 8'h85
`define GPC_IDX_PB_DIR 8'h86
`define GPC_IDX_PC_DIR 8'h87
`define GPC_IDX_SER_STAT 8'h94
`define GPC_IDX_ANALOG 8'h9f

// Field positions
`define GPC_OPT_PULLUP_N 7
`define GPC_OPT_EDGE 6
`define GPC_INT_CHANGE 0
`define GPC_INT_EXT 1
`define GPC_SER_CKE 6
`define GPC_PA_OD_BIT 4
`define GPC_PA_SS_BIT 5

// Reset values
`define GPC_RST_OPTION 8'hff
`define GPC_RST_PA_DIR 6'h3f
`define GPC_RST_PB_DIR 8'hff
`define GPC_RST_ANALOG 8'h00

// Analog config field codes leaving every shared pin digital
`define GPC_PCFG_DIGITAL 3'h3

`endif

// ### rtl/gpc_pkg.sv
package gpc_pkg;
    // AHB transfer kinds; the slave acts on NONSEQ only and ignores the rest
    typedef enum logic [1:0] {
        GPC_IDLE = 2'b00,
        GPC_BUSY = 2'b01,
        GPC_NONSEQ = 2'b10,
        GPC_SEQ = 2'b11
    } gpc_htrans_e;
    // Register index as decoded from haddr[9:2]
    typedef logic [7:0] gpc_idx_t;
endpackage

// ### rtl/gpc_ports.sv
`timescale 1ns/1ps
`include "gpc_cfg.svh"
// Operation
// - Port B direction one tri-states, zero drives
// - Port C same per-bit direction rule
// - Option bit 7 low enables all pull-ups
// - Output pins never get a pull-up
// - Pull-ups off after power-on reset
// - Only upper four input pins compared
// - OR of mismatches sets change flag
// - Change flag wakes device from sleep
// - Port B access ends mismatch, then clear
// - Persisting mismatch keeps setting the flag
// - Port B bit 0 edge interrupt, selectable
// - Unimplemented port A bits read zero
// - Port A bit 4 open-drain, timer clock
// - Peripheral overrides port C direction
// - Select chooses latch or peripheral output
// - I2C levels chosen by status bit 6
// - Read returns pins, write updates latch
// - Analog pins come up analog, read zero
module gpc_ports #(
    parameter int PC_W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [5:0] port_a_in,
    output logic [5:0] port_a_out,
    output logic [5:0] port_a_oe,
    output logic timer_clk_in,
    output logic slave_select_in,
    input wire logic [7:0] port_b_in,
    output logic [7:0] port_b_out,
    output logic [7:0] port_b_oe,
    output logic [7:0] port_b_pullup_en,
    output logic ext_irq_pulse,
    output logic change_irq_flag,
    output logic wake_request,
    input wire logic [PC_W-1:0] port_c_in,
    output logic [PC_W-1:0] port_c_out,
    output logic [PC_W-1:0] port_c_oe,
    input wire logic [PC_W-1:0] periph_sel,
    input wire logic [PC_W-1:0] periph_out,
    input wire logic [PC_W-1:0] periph_oe,
    input wire logic [PC_W-1:0] periph_force_out,
    input wire logic [PC_W-1:0] periph_force_in,
    input wire logic i2c_enable,
    output logic smbus_level_sel
);

    // Bits 3 and 4 of port C carry the I2C pins; refused at elaboration
    if (PC_W < 5 || PC_W > 8) begin : g_bad_pc_w
        $error("PC_W must be 5 to 8");
    end

    // Software-visible state
    logic [7:0] option_control;
    logic [5:0] port_a_latch;
    logic [5:0] port_a_direction;
    logic [7:0] port_b_latch;
    logic [7:0] port_b_direction;
    logic [PC_W-1:0] port_c_latch;
    logic [PC_W-1:0] port_c_direction;
    logic [7:0] analog_pin_config;
    logic [7:0] serial_status;
    logic ext_irq_flag;
    // Reference for change detection
    logic [3:0] change_ref;
    // Previous sample of the external interrupt pin
    logic ext_pin_q;

    // Data-phase bookkeeping of the bus
    logic wr_pend;
    gpc_pkg::gpc_idx_t wr_idx;

    // Address-phase decode
    logic addr_ok;
    logic take;
    gpc_pkg::gpc_idx_t idx;
    logic [7:0] rd_val;
    logic [7:0] wdat;
    logic pb_access;

    // Analog decode and port views
    logic [5:0] analog_mask;
    logic [5:0] port_a_view;
    logic [PC_W-1:0] pc_eff_dir;
    logic [3:0] mismatch;
    logic change_set;
    logic ext_edge;

    // Slave never stalls and never errors
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Word-aligned inside the 1 KiB window; other addresses are unmapped
    assign addr_ok = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'b00);
    assign idx = haddr[9:2];
    assign take = hsel && hready && (htrans == gpc_pkg::GPC_NONSEQ);
    assign wdat = hwdata[7:0];

    assign pb_access = take && addr_ok && (idx == `GPC_IDX_PB_PINS);

    // Codes 011x leave pins digital, all others analog
    assign analog_mask = (analog_pin_config[3:1] == `GPC_PCFG_DIGITAL) ?
        6'h00 : 6'h2f;
    // Analog pins read zero in the data register
    assign port_a_view = port_a_in & ~analog_mask;

    // Read mux, sampled in the address phase
    always_comb begin
        rd_val = 8'h00;
        case (idx)
            `GPC_IDX_PA_PINS: rd_val = {2'b00, port_a_view};
            `GPC_IDX_PB_PINS: rd_val = port_b_in;
            `GPC_IDX_PC_PINS: rd_val = 8'(port_c_in);
            `GPC_IDX_INT_CTRL: rd_val = {6'h00, ext_irq_flag, change_irq_flag};
            `GPC_IDX_OPTION: rd_val = option_control;
            `GPC_IDX_PA_DIR: rd_val = {2'b00, port_a_direction};
            `GPC_IDX_PB_DIR: rd_val = port_b_direction;
            `GPC_IDX_PC_DIR: rd_val = 8'(port_c_direction);
            `GPC_IDX_SER_STAT: rd_val = serial_status;
            // Unused bits 6:4 of the analog config read zero
            `GPC_IDX_ANALOG: rd_val = analog_pin_config & 8'h8f;
            default: rd_val = 8'h00;
        endcase
    end

    // Read data register; zero for unmapped or write transfers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (take) begin
            hrdata <= (addr_ok && !hwrite) ? {24'h0, rd_val} : 32'h0;
        end
    end

    // Latch the write target for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_idx <= 8'h00;
        end else if (hready) begin
            wr_pend <= take && addr_ok && hwrite;
            wr_idx <= idx;
        end
    end

    // Configuration registers, written in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Pull-up disable bit set at reset
            option_control <= `GPC_RST_OPTION;
            port_a_direction <= `GPC_RST_PA_DIR;
            port_b_direction <= `GPC_RST_PB_DIR;
            port_c_direction <= '1;
            // All shared pins analog at reset
            analog_pin_config <= `GPC_RST_ANALOG;
            serial_status <= 8'h00;
        end else if (wr_pend) begin
            case (wr_idx)
                `GPC_IDX_OPTION: option_control <= wdat;
                `GPC_IDX_PA_DIR: port_a_direction <= wdat[5:0];
                `GPC_IDX_PB_DIR: port_b_direction <= wdat;
                `GPC_IDX_PC_DIR: port_c_direction <= wdat[PC_W-1:0];
                `GPC_IDX_ANALOG: analog_pin_config <= wdat;
                `GPC_IDX_SER_STAT: serial_status <= wdat;
                default: ;
            endcase
        end
    end

    // Port writes land in the output latches
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_a_latch <= 6'h00;
            port_b_latch <= 8'h00;
            port_c_latch <= '0;
        end else if (wr_pend) begin
            case (wr_idx)
                `GPC_IDX_PA_PINS: port_a_latch <= wdat[5:0];
                `GPC_IDX_PB_PINS: port_b_latch <= wdat;
                `GPC_IDX_PC_PINS: port_c_latch <= wdat[PC_W-1:0];
                default: ;
            endcase
        end
    end

    // Port A drivers; bit 4 only ever pulls low
    always_comb begin
        port_a_out = port_a_latch;
        port_a_oe = ~port_a_direction;
        // Open drain: drive only a zero
        port_a_out[`GPC_PA_OD_BIT] = 1'b0;
        port_a_oe[`GPC_PA_OD_BIT] = ~port_a_direction[`GPC_PA_OD_BIT] &
            ~port_a_latch[`GPC_PA_OD_BIT];
    end
    // Pin level feeds the timer clock
    assign timer_clk_in = port_a_in[`GPC_PA_OD_BIT];
    // Slave select is a digital input regardless of analog setting
    assign slave_select_in = port_a_in[`GPC_PA_SS_BIT];

    assign port_b_out = port_b_latch;
    assign port_b_oe = ~port_b_direction;
    assign port_b_pullup_en = {8{~option_control[`GPC_OPT_PULLUP_N]}} &
        port_b_direction;

    // Peripheral forcing wins over the direction bit
    // Forcing to output beats forcing to input if both are asserted
    assign pc_eff_dir = (port_c_direction | periph_force_in) & ~periph_force_out;

    // Per-bit port C output mux
    genvar gi;
    generate
        for (gi = 0; gi < PC_W; gi++) begin : g_pc
            assign port_c_out[gi] = periph_sel[gi] ? periph_out[gi] : port_c_latch[gi];
            // Direction zero drives; peripheral enable needs select
            assign port_c_oe[gi] = ~pc_eff_dir[gi] | (periph_sel[gi] & periph_oe[gi]);
        end
    endgenerate

    // SMBus levels only while I2C is enabled
    assign smbus_level_sel = i2c_enable & serial_status[`GPC_SER_CKE];

    // Only upper four input pins compare
    assign mismatch = (port_b_in[7:4] ^ change_ref) & port_b_direction[7:4];
    // Mismatches ORed into one set term
    assign change_set = |mismatch;

    // Reference is re-taken on every port B access, so polling hides changes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            change_ref <= 4'h0;
        end else if (pb_access) begin
            change_ref <= port_b_in[7:4];
        end
    end

    assign ext_edge = option_control[`GPC_OPT_EDGE] ?
        (port_b_in[0] & ~ext_pin_q) : (~port_b_in[0] & ext_pin_q);

    // Previous pin sample for edge detection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_pin_q <= 1'b0;
            ext_irq_pulse <= 1'b0;
        end else begin
            ext_pin_q <= port_b_in[0];
            ext_irq_pulse <= ext_edge;
        end
    end

    // Sticky flags; writing zero clears, a same-cycle event wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            change_irq_flag <= 1'b0;
            ext_irq_flag <= 1'b0;
        end else begin
            // Set each cycle the mismatch persists
            // Clear holds only after mismatch ends
            if (change_set) begin
                change_irq_flag <= 1'b1;
            end else if (wr_pend && wr_idx == `GPC_IDX_INT_CTRL &&
                !wdat[`GPC_INT_CHANGE]) begin
                change_irq_flag <= 1'b0;
            end
            // Edge events latch into a flag
            if (ext_edge) begin
                ext_irq_flag <= 1'b1;
            end else if (wr_pend && wr_idx == `GPC_IDX_INT_CTRL &&
                !wdat[`GPC_INT_EXT]) begin
                ext_irq_flag <= 1'b0;
            end
        end
    end

    // Change flag requests wake from sleep
    assign wake_request = change_irq_flag;

    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // A write to the port B data register in its two phases
    sequence pb_write_s;
        pb_access && hwrite ##1 hready;
    endsequence

    pb_drive_a: assert property (port_b_oe == ~port_b_direction)
        else $error("port B enable not from direction");
    pc_drive_a: assert property ((periph_sel == '0 && periph_force_out == '0 &&
        periph_force_in == '0) |-> port_c_oe == ~port_c_direction)
        else $error("port C enable not from direction");
    pullup_gate_a: assert property (port_b_pullup_en ==
        ({8{~option_control[7]}} & port_b_direction))
        else $error("pull-up on an output pin");
    change_set_a: assert property (change_set |=> change_irq_flag)
        else $error("mismatch did not set change flag");
    flag_hold_a: assert property (change_irq_flag && change_set |=>
        change_irq_flag [*1])
        else $error("flag cleared during mismatch");
    pb_latch_a: assert property (pb_write_s |=>
        port_b_out == $past(hwdata[7:0]))
        else $error("port B latch not written");
    ref_take_a: assert property (pb_access |=>
        change_ref == $past(port_b_in[7:4]))
        else $error("reference not captured");
    ext_edge_a: assert property (option_control[6] && $rose(port_b_in[0]) |->
        ##1 ext_irq_pulse ##0 ext_irq_flag)
        else $error("rising edge missed");
    pa_unused_a: assert property (take && addr_ok && !hwrite &&
        idx == 8'h05 |=> hrdata[31:6] == 26'h0)
        else $error("port A upper bits not zero");
    od_drive_a: assert property (port_a_oe[4] |-> !port_a_out[4] &&
        !port_a_latch[4])
        else $error("open-drain pin driven high");
    pc_force_a: assert property (periph_force_out[PC_W-1] && !periph_sel[PC_W-1] |->
        port_c_oe[PC_W-1])
        else $error("force to output ignored");
    pc_sel_a: assert property (!periph_sel[1] && port_c_direction[1] &&
        !periph_force_out[1] |-> !port_c_oe[1])
        else $error("peripheral enable without select");
    smbus_sel_a: assert property (!i2c_enable |-> !smbus_level_sel)
        else $error("levels switched without I2C");
    analog_zero_a: assert property (take && addr_ok && !hwrite && idx == 8'h05 &&
        analog_pin_config[3:1] != 3'h3 |=> (hrdata[5:0] & 6'h2f) == 6'h00)
        else $error("analog pin reads nonzero");

endmodule

// ### bench/gpc_pin_model.sv
`timescale 1ns/1ps
// Far-side pins: outside drivers and the weak pull-ups meet the chip drivers
module gpc_pin_model #(
    parameter int W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] pu,
    input wire logic [W-1:0] ext_drv,
    input wire logic [W-1:0] ext,
    output logic [W-1:0] pin
);
    // Floating level that changes every cycle, so a stale value never passes
    logic [W-1:0] wander;
    // Wander pattern flips on each rising edge of hclk
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wander <= '0;
        end else begin
            wander <= ~wander;
        end
    end
    // chip drive wins, then outside, then pull-up
    assign pin = (oe & out) | (~oe & ext_drv & ext) | (~oe & ~ext_drv & (pu | wander));
endmodule

// ### bench/gpio_ports_abc_change_irq_tb.sv
`timescale 1ns/1ps
module gpio_ports_abc_change_irq_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, tclk, ssel, xpulse, cflag, wake, smb;
    logic [5:0] pa_in, pa_out, pa_oe;
    logic [7:0] pb_in, pb_out, pb_oe, pb_pu, pc_in, pc_out, pc_oe;
    // Outside levels and peripheral requests
    logic [7:0] ext_b = 8'hf0;
    logic [7:0] drv_b = 8'hff, ext_c = 8'h3c, pfi = 8'h00;
    logic [5:0] ext_a = 6'h3f;
    logic [7:0] psel = 8'h00, pout = 8'hff, poe = 8'h00, pfo = 8'h00;
    logic i2c_en = 1'b0;
    int n_fail = 0, compares = 0, n_pulse = 0;
    // Rows: write flag, register index, write data, expected read
    localparam int NR = 13;
    logic [24:0] rows [NR] = '{{1'b0, 8'h81, 8'h00, 8'hff}, {1'b0, 8'h86, 8'h00, 8'hff},
        {1'b0, 8'h85, 8'h00, 8'h3f}, {1'b0, 8'h9f, 8'h00, 8'h00}, {1'b0, 8'h40, 8'h00, 8'h00},
        {1'b1, 8'h40, 8'h55, 8'h00}, {1'b0, 8'h40, 8'h00, 8'h00}, {1'b1, 8'h81, 8'h7f, 8'h00},
        {1'b0, 8'h81, 8'h00, 8'h7f}, {1'b1, 8'h86, 8'hf0, 8'h00}, {1'b0, 8'h86, 8'h00, 8'hf0},
        {1'b1, 8'h85, 8'hef, 8'h00}, {1'b0, 8'h85, 8'h00, 8'h2f}};

    gpc_ports u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port_a_in(pa_in),
        .port_a_out(pa_out), .port_a_oe(pa_oe), .timer_clk_in(tclk), .slave_select_in(ssel),
        .port_b_in(pb_in), .port_b_out(pb_out), .port_b_oe(pb_oe), .port_b_pullup_en(pb_pu),
        .ext_irq_pulse(xpulse), .change_irq_flag(cflag), .wake_request(wake),
        .port_c_in(pc_in), .port_c_out(pc_out), .port_c_oe(pc_oe), .periph_sel(psel),
        .periph_out(pout), .periph_oe(poe), .periph_force_out(pfo),
        .periph_force_in(pfi), .i2c_enable(i2c_en), .smbus_level_sel(smb));
    gpc_pin_model #(.W(6)) u_pa (.hclk(hclk), .hresetn(hresetn), .oe(pa_oe), .out(pa_out),
        .pu(6'h00), .ext_drv(6'h3f), .ext(ext_a), .pin(pa_in));
    gpc_pin_model #(.W(8)) u_pb (.hclk(hclk), .hresetn(hresetn), .oe(pb_oe), .out(pb_out),
        .pu(pb_pu), .ext_drv(drv_b), .ext(ext_b), .pin(pb_in));
    gpc_pin_model #(.W(8)) u_pc (.hclk(hclk), .hresetn(hresetn), .oe(pc_oe), .out(pc_out),
        .pu(8'h00), .ext_drv(8'hff), .ext(ext_c), .pin(pc_in));

    // Free-running bus clock
    always #50 hclk = ~hclk;
    // Count one-cycle edge pulses
    always @(posedge hclk) begin
        if (xpulse === 1'b1) begin
            n_pulse++;
        end
    end

    // Single word transfer; waits on the slave, never on a fixed count
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Compare one value and log a mismatch
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    // Step to a settled point after the last write landed
    task automatic settle(input int n);
        repeat (n) @(negedge hclk);
    endtask
    task automatic give_verdict();
        $display("compares %0d, n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Hang guard, far beyond the roughly 140 cycles the tests need
    initial begin
        #1000000;
        n_fail++;
        give_verdict();
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        settle(1);
        chk("pullup_en", 32'h00, 32'(pb_pu));
        chk("port_b_oe", 32'h00, 32'(pb_oe));
        for (int i = 0; i < NR; i++) begin
            bus(rows[i][24], rows[i][23:16], rows[i][15:8]);
            if (!rows[i][24]) chk("reg read", {24'h0, rows[i][7:0]}, rd);
        end
        $display("test register table done");
        // Direction bit 3 already clear while pull-ups are on
        bus(1'b1, 8'h06, 8'h5a);
        settle(1);
        chk("pullup_en", 32'hf0, 32'(pb_pu));
        chk("port_b_oe", 32'h0f, 32'(pb_oe));
        chk("port_b_out", 32'h5a, 32'(pb_out));
        // Outside drivers let go of the upper pins; pull-ups must hold them high
        @(posedge hclk);
        drv_b <= 8'h0f;
        bus(1'b0, 8'h06, 8'h00);
        chk("port_b read", 32'hfa, rd);
        chk("hresp", 32'd0, 32'(hresp));
        drv_b <= 8'hff;
        bus(1'b1, 8'h06, 8'h5b);
        settle(3);
        chk("rise pulses", 32'd1, 32'(n_pulse));
        bus(1'b1, 8'h81, 8'h3f);
        bus(1'b1, 8'h06, 8'h5a);
        settle(3);
        chk("fall pulses", 32'd2, 32'(n_pulse));
        bus(1'b0, 8'h0b, 8'h00);
        chk("ext flag", 32'h02, rd & 32'h02);
        $display("test port b drive done");
        bus(1'b1, 8'h0b, 8'h00);
        settle(1);
        chk("flag idle", 32'd0, 32'(cflag));
        @(posedge hclk);
        ext_b <= 8'hd0;
        settle(3);
        chk("change flag", 32'd1, 32'(cflag));
        chk("wake", 32'd1, 32'(wake));
        bus(1'b0, 8'h0b, 8'h00);
        chk("int ctrl read", 32'h01, rd);
        bus(1'b1, 8'h0b, 8'h00);
        settle(1);
        chk("flag held", 32'd1, 32'(cflag));
        // A single read; polling would keep re-latching the reference
        bus(1'b0, 8'h06, 8'h00);
        bus(1'b1, 8'h0b, 8'h00);
        settle(1);
        chk("flag cleared", 32'd0, 32'(cflag));
        bus(1'b1, 8'h86, 8'h70);
        settle(3);
        chk("output excluded", 32'd0, 32'(cflag));
        $display("test change detect done");
        bus(1'b0, 8'h05, 8'h00);
        chk("analog read", 32'h00, rd);
        // Pin code 0110 also suits a slave-select user
        bus(1'b1, 8'h9f, 8'h06);
        bus(1'b0, 8'h05, 8'h00);
        chk("digital read", 32'h2f, rd);
        chk("od enable", 32'h10, 32'(pa_oe));
        chk("od level", 32'h00, 32'(pa_out & 6'h10));
        bus(1'b1, 8'h05, 8'h10);
        settle(1);
        chk("od release", 32'h00, 32'(pa_oe));
        chk("timer clock", 32'd1, 32'(tclk));
        chk("slave select", 32'd1, 32'(ssel));
        bus(1'b0, 8'h05, 8'h00);
        chk("released read", 32'h3f, rd);
        @(posedge hclk);
        ext_a <= 6'h1f;
        settle(1);
        chk("slave select low", 32'd0, 32'(ssel));
        $display("test port a done");
        // Whole-register writes only, never bit updates
        bus(1'b1, 8'h87, 8'h00);
        bus(1'b1, 8'h07, 8'ha5);
        settle(1);
        chk("pc oe", 32'hff, 32'(pc_oe));
        chk("pc out", 32'ha5, 32'(pc_out));
        @(posedge hclk);
        psel <= 8'h01;
        pout <= 8'h00;
        poe <= 8'h02;
        settle(1);
        chk("pc select", 32'ha4, 32'(pc_out));
        bus(1'b1, 8'h87, 8'hff);
        settle(1);
        chk("pc oe gated", 32'h00, 32'(pc_oe));
        @(posedge hclk);
        poe <= 8'h03;
        pfo <= 8'h80;
        settle(1);
        chk("pc override", 32'h81, 32'(pc_oe));
        // Force-in turns outputs around; force-out still wins on bit 7
        bus(1'b1, 8'h87, 8'h00);
        pfi <= 8'h8c;
        settle(1);
        chk("pc force in", 32'hf3, 32'(pc_oe));
        bus(1'b0, 8'h07, 8'h00);
        chk("pc read", 32'hac, rd);
        bus(1'b1, 8'h94, 8'h40);
        i2c_en <= 1'b1;
        settle(1);
        chk("smbus on", 32'd1, 32'(smb));
        @(posedge hclk);
        i2c_en <= 1'b0;
        settle(1);
        chk("smbus off", 32'd0, 32'(smb));
        $display("test port c done");
        give_verdict();
    end
endmodule
